// File: design/status_flag_pkg.sv
/*
 * Constants for the controller status flag word block: register map, flag bit
 * positions, reset values and field widths.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package status_flag_pkg;

	// ==========================================================
	// Register byte offsets.
	localparam logic [7:0] OFF_FLAGS = 8'h00;
	localparam logic [7:0] OFF_SELF_TEST_CODE = 8'h04;
	localparam logic [7:0] OFF_FIRST_ERR_ADDR = 8'h08;
	localparam logic [7:0] OFF_LATEST_ERR_ADDR = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
	localparam logic [7:0] OFF_SCAN_TARGET = 8'h18;
	localparam logic [7:0] OFF_CONTROL = 8'h1C;

	// ==========================================================
	// Bit positions inside the special status flag word.
	localparam int BIT_SELF_TEST = 0;
	localparam int BIT_UNUSED = 1;
	localparam int BIT_CASSETTE_IO = 2;
	localparam int BIT_CASSETTE = 3;
	localparam int BIT_IO_VERIFY = 4;
	localparam int BIT_BATT_LIVE = 5;
	localparam int BIT_BATT_HOLD = 6;
	localparam int BIT_OP_ERR_HOLD = 7;
	localparam int BIT_OP_ERR_PULSE = 8;
	localparam int BIT_CARRY = 9;
	localparam int BIT_GREATER = 10;
	localparam int BIT_EQUAL = 11;
	localparam int BIT_LESS = 12;
	localparam int BIT_AUX_TIMER = 13;
	localparam int BIT_TOOL_PORT = 14;
	localparam int BIT_SCAN_OVER = 15;

	// ==========================================================
	// Control register fields.
	localparam int CTRL_CONST_SCAN = 0;
	localparam int CTRL_BATT_NOTIFY = 1;

	// ==========================================================
	// Widths and reset values.
	localparam int FLAG_W = 16;
	localparam int DATA_W = 16;
	localparam logic [15:0] FLAGS_RESET = 16'h0000;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [15:0] SCAN_TARGET_RESET = 16'h0000;
	localparam logic [1:0] CONTROL_RESET = 2'h2;
	localparam logic [15:0] BATT_IRQ_BITS = 16'h0060;

endpackage

// File: design/status_flag_word.sv
/*
 * Special status flag word of a programmable controller, with its diagnostic
 * data registers, an interrupt status and mask pair, and an Avalon-MM slave.
 * Assumes the condition inputs come from controller logic on i_clock, except
 * the battery monitor level, which arrives from a pin and is synchronised.
 */
`timescale 1ns/1ps

module status_flag_word
	import status_flag_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic [7:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	output logic o_irq,
	input wire logic i_init,
	input wire logic i_self_test_fault,
	input wire logic [DATA_W-1:0] i_self_test_code,
	input wire logic i_cassette_io_fault,
	input wire logic i_cassette_fault,
	input wire logic i_io_verify_fault,
	input wire logic i_battery_fault_pin,
	input wire logic i_op_error,
	input wire logic [ADDR_W-1:0] i_op_error_addr,
	input wire logic i_arith_valid,
	input wire logic i_arith_carry,
	input wire logic i_arith_zero,
	input wire logic i_shift_valid,
	input wire logic i_shift_carry,
	input wire logic i_cmp_valid,
	input wire logic i_cmp_gt,
	input wire logic i_cmp_eq,
	input wire logic i_cmp_lt,
	input wire logic i_aux_timer_zero,
	input wire logic i_aux_trigger,
	input wire logic i_tool_port_fault,
	input wire logic i_scan_end,
	input wire logic [15:0] i_scan_time
);

	// ==========================================================
	// Declarations.
	logic batt_meta_r, batt_sync_r;
	logic self_test_r, cassette_io_r, cassette_r, io_verify_r, tool_port_r;
	logic batt_live_r, batt_hold_r, op_hold_r, op_pulse_r;
	logic carry_r, greater_r, equal_r, less_r, aux_timer_r, scan_over_r;
	logic [FLAG_W-1:0] flags, flags_prev_r, irq_events;
	logic [FLAG_W-1:0] irq_status_r, irq_status_nxt, irq_mask_r;
	logic [DATA_W-1:0] self_test_code_r;
	logic [ADDR_W-1:0] first_err_addr_r, latest_err_addr_r;
	logic [15:0] scan_target_r;
	logic [1:0] control_r;
	logic ack_r, bus_req, wr_ack, rd_ack;
	logic [31:0] rd_mux;

	// Merges the low two write lanes into a 16-bit register value.
	function automatic logic [15:0] merge16(input logic [15:0] old_val, input logic [31:0] wdata,
		input logic [3:0] be);
		logic [15:0] res;
		res = old_val;
		if (be[0]) begin
			res[7:0] = wdata[7:0];
		end
		if (be[1]) begin
			res[15:8] = wdata[15:8];
		end
		return res;
	endfunction

	// ==========================================================
	// Bus handshake: every access waits exactly one cycle.
	assign bus_req = i_read | i_write;
	assign o_waitrequest = bus_req & ~ack_r;
	assign wr_ack = i_write & ack_r;
	assign rd_ack = i_read & ack_r;

	// The acknowledge toggles up for one cycle after a request is seen.
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= bus_req & ~ack_r;
		end
	end

	// ==========================================================
	// Battery pin synchroniser; the first stage feeds only the second.
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			batt_meta_r <= 1'b0;
			batt_sync_r <= 1'b0;
		end else begin
			batt_meta_r <= i_battery_fault_pin;
			batt_sync_r <= batt_meta_r;
		end
	end

	// ==========================================================
	// Fault flags from diagnostics, cassettes, verification and tool port.
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			self_test_r <= 1'b0;
			self_test_code_r <= '0;
		end else if (i_self_test_fault) begin
			self_test_r <= 1'b1;
			self_test_code_r <= i_self_test_code;
		end else if (i_init) begin
			self_test_r <= 1'b0;
		end
	end

	// Cassette, verification and tool port flags mirror their fault levels.
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			cassette_io_r <= 1'b0;
			cassette_r <= 1'b0;
			io_verify_r <= 1'b0;
			tool_port_r <= 1'b0;
		end else begin
			cassette_io_r <= i_cassette_io_fault;
			cassette_r <= i_cassette_fault;
			io_verify_r <= i_io_verify_fault;
			tool_port_r <= i_tool_port_fault;
		end
	end

	// ==========================================================
	// Battery flags: the live copy ignores the notification setting.
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			batt_live_r <= 1'b0;
			batt_hold_r <= 1'b0;
		end else begin
			batt_live_r <= batt_sync_r;
			if (batt_sync_r) begin
				batt_hold_r <= 1'b1;
			end else if (i_init) begin
				batt_hold_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Operation error flags and the two error address registers.
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			op_hold_r <= 1'b0;
			op_pulse_r <= 1'b0;
			first_err_addr_r <= '0;
			latest_err_addr_r <= '0;
		end else begin
			op_pulse_r <= i_op_error;
			if (i_op_error) begin
				latest_err_addr_r <= i_op_error_addr;
			end
			if (i_op_error && !op_hold_r) begin
				op_hold_r <= 1'b1;
				first_err_addr_r <= i_op_error_addr;
			end else if (i_init && !i_op_error) begin
				op_hold_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Carry and compare flags; compare and equal flags last one cycle.
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			carry_r <= 1'b0;
		end else if (i_arith_valid) begin
			carry_r <= i_arith_carry;
		end else if (i_shift_valid) begin
			carry_r <= i_shift_carry;
		end
	end

	// Momentary compare results.
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			greater_r <= 1'b0;
			equal_r <= 1'b0;
			less_r <= 1'b0;
		end else begin
			greater_r <= i_cmp_valid & i_cmp_gt;
			equal_r <= (i_cmp_valid & i_cmp_eq) | (i_arith_valid & i_arith_zero);
			less_r <= i_cmp_valid & i_cmp_lt;
		end
	end

	// ==========================================================
	// Auxiliary timer contact; a dropped trigger wins over count zero.
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			aux_timer_r <= 1'b0;
		end else if (!i_aux_trigger) begin
			aux_timer_r <= 1'b0;
		end else if (i_aux_timer_zero) begin
			aux_timer_r <= 1'b1;
		end
	end

	// ==========================================================
	// Scan overrun, judged at each scan end while constant scan is on.
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			scan_over_r <= 1'b0;
		end else if (i_scan_end && control_r[CTRL_CONST_SCAN] &&
			(scan_target_r == 16'h0000 || i_scan_time > scan_target_r)) begin
			scan_over_r <= 1'b1;
		end else if (i_init) begin
			scan_over_r <= 1'b0;
		end
	end

	// ==========================================================
	// Flag word assembly; the unused position is tied low.
	always_comb begin
		flags = FLAGS_RESET;
		flags[BIT_SELF_TEST] = self_test_r;
		flags[BIT_UNUSED] = 1'b0;
		flags[BIT_CASSETTE_IO] = cassette_io_r;
		flags[BIT_CASSETTE] = cassette_r;
		flags[BIT_IO_VERIFY] = io_verify_r;
		flags[BIT_BATT_LIVE] = batt_live_r;
		flags[BIT_BATT_HOLD] = batt_hold_r;
		flags[BIT_OP_ERR_HOLD] = op_hold_r;
		flags[BIT_OP_ERR_PULSE] = op_pulse_r;
		flags[BIT_CARRY] = carry_r;
		flags[BIT_GREATER] = greater_r;
		flags[BIT_EQUAL] = equal_r;
		flags[BIT_LESS] = less_r;
		flags[BIT_AUX_TIMER] = aux_timer_r;
		flags[BIT_TOOL_PORT] = tool_port_r;
		flags[BIT_SCAN_OVER] = scan_over_r;
	end

	// ==========================================================
	// Interrupts: a rising flag sets its status bit; battery events need notify.
	assign irq_events = flags & ~flags_prev_r &
		(control_r[CTRL_BATT_NOTIFY] ? {FLAG_W{1'b1}} : ~BATT_IRQ_BITS);

	// Write-one-to-clear, with a new event winning over the clear.
	always_comb begin
		irq_status_nxt = irq_status_r;
		if (wr_ack && i_address == OFF_IRQ_STATUS) begin
			irq_status_nxt = irq_status_r & ~merge16(16'h0000, i_writedata, i_byteenable);
		end
		irq_status_nxt = irq_status_nxt | irq_events;
	end

	// Previous flags and the sticky status.
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			flags_prev_r <= FLAGS_RESET;
			irq_status_r <= '0;
		end else begin
			flags_prev_r <= flags;
			irq_status_r <= irq_status_nxt;
		end
	end

	assign o_irq = |(irq_status_r & irq_mask_r);

	// ==========================================================
	// Writable registers; the flag word and data registers take no writes.
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			irq_mask_r <= MASK_RESET;
			scan_target_r <= SCAN_TARGET_RESET;
			control_r <= CONTROL_RESET;
		end else if (wr_ack) begin
			unique case (i_address)
				OFF_IRQ_MASK: begin
					irq_mask_r <= merge16(irq_mask_r, i_writedata, i_byteenable);
				end
				OFF_SCAN_TARGET: begin
					scan_target_r <= merge16(scan_target_r, i_writedata, i_byteenable);
				end
				OFF_CONTROL: begin
					if (i_byteenable[0]) begin
						control_r <= i_writedata[1:0];
					end
				end
				default: begin
					control_r <= control_r;
				end
			endcase
		end
	end

	// ==========================================================
	// Read multiplexer; the flag word is read only through this path, while its rising edges also reach o_irq.
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (i_address)
			OFF_FLAGS: rd_mux[FLAG_W-1:0] = flags;
			OFF_SELF_TEST_CODE: rd_mux[DATA_W-1:0] = self_test_code_r;
			OFF_FIRST_ERR_ADDR: rd_mux[ADDR_W-1:0] = first_err_addr_r;
			OFF_LATEST_ERR_ADDR: rd_mux[ADDR_W-1:0] = latest_err_addr_r;
			OFF_IRQ_STATUS: rd_mux[FLAG_W-1:0] = irq_status_r;
			OFF_IRQ_MASK: rd_mux[FLAG_W-1:0] = irq_mask_r;
			OFF_SCAN_TARGET: rd_mux[15:0] = scan_target_r;
			OFF_CONTROL: rd_mux[1:0] = control_r;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is captured while the master waits and stands at the answer.
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_readdata <= 32'h0000_0000;
		end else if (i_read && !ack_r) begin
			o_readdata <= rd_mux;
		end
	end

	// ==========================================================
	// Checks.
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rstn);

	sequence op_err_again;
		i_op_error && op_hold_r && !i_init;
	endsequence

	sequence flag_write;
		wr_ack && i_address == OFF_FLAGS && !i_self_test_fault && !i_init;
	endsequence

	chk_flag_write_ignored: assert property (flag_write |=> $stable(self_test_r))
		else $error("Write to the flag word changed a flag.");
	chk_flag_read_back: assert property ((i_read && !ack_r && i_address == OFF_FLAGS) |=>
		o_readdata[15:0] == $past(flags) ##1 o_readdata[1] == 1'b0)
		else $error("Flag word read returned wrong value.");
	chk_self_test_code: assert property (i_self_test_fault |=>
		self_test_r && self_test_code_r == $past(i_self_test_code))
		else $error("Self test fault not recorded.");
	chk_battery_live: assert property (i_battery_fault_pin |=> ##2 batt_live_r)
		else $error("Live battery flag did not follow the pin.");
	chk_battery_hold: assert property ((batt_hold_r && !i_init) |=> batt_hold_r)
		else $error("Held battery flag dropped without initialise.");
	chk_first_addr_once: assert property (op_err_again |=> $stable(first_err_addr_r) && op_hold_r)
		else $error("First error address was overwritten.");
	chk_latest_addr: assert property (i_op_error |=>
		op_pulse_r && latest_err_addr_r == $past(i_op_error_addr))
		else $error("Latest error address or pulse wrong.");
	chk_op_pulse_clear: assert property (!i_op_error |=> !op_pulse_r)
		else $error("Operation error pulse held too long.");
	chk_greater_pulse: assert property (greater_r |-> $past(i_cmp_valid && i_cmp_gt))
		else $error("Greater flag without a compare.");
	chk_equal_cause: assert property (equal_r |-> $past((i_cmp_valid && i_cmp_eq) ||
		(i_arith_valid && i_arith_zero)))
		else $error("Equal flag without a cause.");
	chk_less_pulse: assert property ((i_cmp_valid && i_cmp_lt) |=> less_r ##1 (less_r == $past(i_cmp_valid && i_cmp_lt)))
		else $error("Less flag did not pulse.");
	chk_aux_timer_off: assert property (!i_aux_trigger |=> !aux_timer_r)
		else $error("Auxiliary timer flag stayed on without trigger.");
	chk_scan_overrun: assert property ((i_scan_end && control_r[CTRL_CONST_SCAN] &&
		(scan_target_r == 16'h0000 || i_scan_time > scan_target_r)) |=> scan_over_r)
		else $error("Scan overrun not flagged.");
	chk_bus_answer: assert property ((bus_req && o_waitrequest) |=> !o_waitrequest)
		else $error("Bus answer took longer than one wait cycle.");

endmodule

// File: bench/testbench.sv
/*
 * Self-checking testbench for the controller status flag word block.
 * Assumes the design package and module are compiled first and that the
 * Avalon-MM slave answers with one wait cycle per access.
 */
`timescale 1ns/1ps

module testbench
	import status_flag_pkg::*;
();

	// ==========================================================
	// Signals and the block under test.
	logic i_clock, i_rstn, i_read, i_write, o_waitrequest, o_irq, i_init;
	logic [7:0] i_address;
	logic [31:0] i_writedata, o_readdata;
	logic [3:0] i_byteenable;
	logic i_self_test_fault, i_cassette_io_fault, i_cassette_fault, i_io_verify_fault, i_battery_fault_pin;
	logic i_op_error, i_arith_valid, i_arith_carry, i_arith_zero, i_shift_valid, i_shift_carry;
	logic i_cmp_valid, i_cmp_gt, i_cmp_eq, i_cmp_lt, i_aux_timer_zero, i_aux_trigger, i_tool_port_fault;
	logic i_scan_end;
	logic [DATA_W-1:0] i_self_test_code;
	logic [15:0] i_op_error_addr, i_scan_time;
	int fail_count, checks_done;

	status_flag_word u_status_flag_word (
		.i_clock(i_clock), .i_rstn(i_rstn), .i_address(i_address), .i_read(i_read), .i_write(i_write),
		.i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest), .o_irq(o_irq), .i_init(i_init), .i_self_test_fault(i_self_test_fault),
		.i_self_test_code(i_self_test_code), .i_cassette_io_fault(i_cassette_io_fault),
		.i_cassette_fault(i_cassette_fault), .i_io_verify_fault(i_io_verify_fault),
		.i_battery_fault_pin(i_battery_fault_pin), .i_op_error(i_op_error), .i_op_error_addr(i_op_error_addr),
		.i_arith_valid(i_arith_valid), .i_arith_carry(i_arith_carry), .i_arith_zero(i_arith_zero),
		.i_shift_valid(i_shift_valid), .i_shift_carry(i_shift_carry), .i_cmp_valid(i_cmp_valid),
		.i_cmp_gt(i_cmp_gt), .i_cmp_eq(i_cmp_eq), .i_cmp_lt(i_cmp_lt), .i_aux_timer_zero(i_aux_timer_zero),
		.i_aux_trigger(i_aux_trigger), .i_tool_port_fault(i_tool_port_fault), .i_scan_end(i_scan_end),
		.i_scan_time(i_scan_time)
	);

	// Clock of 50 ns period.
	always #25 i_clock = ~i_clock;

	// ==========================================================
	// Shared tasks.
	task automatic end_of_test();
		$display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			$display("ERROR %0t: %s got %h expected %h", $time, msg, got, exp);
			fail_count++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
	endtask

	// One bus access; the request is held until waitrequest is sampled low, then an idle cycle follows.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		i_address <= a;
		i_writedata <= wd;
		i_write <= wr;
		i_read <= ~wr;
		@(posedge i_clock);
		while (o_waitrequest !== 1'b0 && n < 50) begin
			@(posedge i_clock);
			n++;
		end
		rd = o_readdata;
		i_write <= 1'b0;
		i_read <= 1'b0;
		if (n == 50) begin
			chk(32'h1, 32'h0, "bus answer timeout");
			end_of_test();
		end
		@(posedge i_clock);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, exp, msg);
	endtask

	// Pulses system initialisation and clears any collected interrupt status.
	task automatic do_init();
		i_init <= 1'b1;
		cyc(1);
		i_init <= 1'b0;
		cyc(1);
		wr(OFF_IRQ_STATUS, 32'hFFFF);
	endtask

	task automatic scan(input logic [15:0] t);
		i_scan_time <= t;
		i_scan_end <= 1'b1;
		cyc(1);
		i_scan_end <= 1'b0;
		cyc(2);
	endtask

	// ==========================================================
	// Scenarios.
	task automatic t_reset();
		rd_chk(OFF_FLAGS, 32'h0, "flags after reset");
		rd_chk(OFF_IRQ_MASK, 32'h0, "mask after reset");
		rd_chk(OFF_SCAN_TARGET, 32'h0, "scan target after reset");
		rd_chk(OFF_CONTROL, 32'h2, "control after reset");
		rd_chk(OFF_IRQ_STATUS, 32'h0, "irq status after reset");
		rd_chk(8'h20, 32'h0, "unmapped read");
		chk({31'h0, o_irq}, 32'h0, "irq line after reset");
	endtask

	// Writes to read-only places and to an unmapped offset must change nothing.
	task automatic t_readonly();
		wr(OFF_FLAGS, 32'hFFFF);
		wr(OFF_SELF_TEST_CODE, 32'hBEEF);
		wr(OFF_FIRST_ERR_ADDR, 32'hBEEF);
		wr(OFF_LATEST_ERR_ADDR, 32'hBEEF);
		wr(8'h24, 32'hFFFF);
		rd_chk(OFF_FLAGS, 32'h0, "flag word written");
		rd_chk(OFF_SELF_TEST_CODE, 32'h0, "fault code written");
		rd_chk(OFF_FIRST_ERR_ADDR, 32'h0, "first address written");
		rd_chk(OFF_LATEST_ERR_ADDR, 32'h0, "latest address written");
		rd_chk(8'h24, 32'h0, "unmapped write");
	endtask

	task automatic t_self_test();
		i_self_test_code <= 16'hA5C3;
		i_self_test_fault <= 1'b1;
		cyc(1);
		i_self_test_fault <= 1'b0;
		i_self_test_code <= 16'h0000;
		cyc(2);
		rd_chk(OFF_FLAGS, 32'h1, "self test flag");
		rd_chk(OFF_SELF_TEST_CODE, 32'hA5C3, "self test code");
		do_init();
		rd_chk(OFF_FLAGS, 32'h0, "self test flag after init");
	endtask

	// Each level source is raised alone and must show on its own bit only.
	task automatic t_levels();
		for (int i = 0; i < 4; i++) begin
			{i_tool_port_fault, i_io_verify_fault, i_cassette_fault, i_cassette_io_fault} <= 4'h1 << i;
			cyc(2);
			rd_chk(OFF_FLAGS, 32'({i == 3, 9'h0, i == 2, i == 1, i == 0, 2'h0}), "level flag");
		end
		{i_tool_port_fault, i_io_verify_fault, i_cassette_fault, i_cassette_io_fault} <= 4'h0;
		cyc(2);
		rd_chk(OFF_FLAGS, 32'h0, "level flags released");
		wr(OFF_IRQ_STATUS, 32'hFFFF);
	endtask

	// Battery flags with notification switched off: live follows, held latches until init.
	task automatic t_battery();
		wr(OFF_CONTROL, 32'h0);
		i_battery_fault_pin <= 1'b1;
		cyc(5);
		rd_chk(OFF_FLAGS, 32'h60, "battery fault flags");
		rd_chk(OFF_IRQ_STATUS, 32'h0, "battery events without notify");
		i_battery_fault_pin <= 1'b0;
		cyc(5);
		rd_chk(OFF_FLAGS, 32'h40, "battery recovered");
		do_init();
		rd_chk(OFF_FLAGS, 32'h0, "battery held after init");
		wr(OFF_CONTROL, 32'h2);
	endtask

	// With notify on both battery events are collected; a reset, standing in for power-off, drops the held flag.
	task automatic t_power_off();
		i_battery_fault_pin <= 1'b1;
		cyc(5);
		rd_chk(OFF_IRQ_STATUS, 32'h60, "battery events with notify");
		i_battery_fault_pin <= 1'b0;
		cyc(5);
		rd_chk(OFF_FLAGS, 32'h40, "battery held before power-off");
		i_rstn <= 1'b0;
		cyc(2);
		i_rstn <= 1'b1;
		cyc(1);
		rd_chk(OFF_FLAGS, 32'h0, "battery held after power-off");
		rd_chk(OFF_IRQ_STATUS, 32'h0, "irq status after power-off");
		rd_chk(OFF_CONTROL, 32'h2, "control after power-off");
	endtask

	// Two operation errors on consecutive cycles.
	task automatic t_op_error();
		i_op_error <= 1'b1;
		i_op_error_addr <= 16'h1234;
		cyc(1);
		i_op_error_addr <= 16'h5678;
		cyc(1);
		i_op_error <= 1'b0;
		cyc(2);
		rd_chk(OFF_FLAGS, 32'h80, "op error flags");
		rd_chk(OFF_FIRST_ERR_ADDR, 32'h1234, "first error address");
		rd_chk(OFF_LATEST_ERR_ADDR, 32'h5678, "latest error address");
		rd_chk(OFF_IRQ_STATUS, 32'h180, "op error events");
		do_init();
	endtask

	task automatic t_arith();
		i_arith_valid <= 1'b1;
		i_arith_carry <= 1'b1;
		cyc(1);
		i_arith_valid <= 1'b0;
		i_arith_carry <= 1'b0;
		cyc(2);
		rd_chk(OFF_FLAGS, 32'h200, "carry on overflow");
		i_shift_valid <= 1'b1;
		cyc(1);
		i_shift_valid <= 1'b0;
		cyc(2);
		rd_chk(OFF_FLAGS, 32'h0, "carry from shift");
		i_shift_valid <= 1'b1;
		i_shift_carry <= 1'b1;
		cyc(1);
		i_shift_valid <= 1'b0;
		i_shift_carry <= 1'b0;
		cyc(2);
		rd_chk(OFF_FLAGS, 32'h200, "carry set by shift");
		wr(OFF_IRQ_STATUS, 32'hFFFF);
		i_arith_valid <= 1'b1;
		i_arith_zero <= 1'b1;
		cyc(1);
		i_arith_valid <= 1'b0;
		i_arith_zero <= 1'b0;
		cyc(2);
		rd_chk(OFF_IRQ_STATUS, 32'h800, "equal on zero result");
		wr(OFF_IRQ_STATUS, 32'hFFFF);
	endtask

	// Each compare outcome in turn; the flags are momentary, so the events are read.
	task automatic t_compare();
		for (int i = 0; i < 3; i++) begin
			{i_cmp_gt, i_cmp_eq, i_cmp_lt} <= 3'h4 >> i;
			i_cmp_valid <= 1'b1;
			cyc(1);
			i_cmp_valid <= 1'b0;
			cyc(2);
			rd_chk(OFF_IRQ_STATUS, 32'h400 << i, "compare event");
			wr(OFF_IRQ_STATUS, 32'hFFFF);
		end
		rd_chk(OFF_FLAGS, 32'h0, "compare flags momentary");
	endtask

	task automatic t_aux();
		i_aux_trigger <= 1'b1;
		cyc(2);
		rd_chk(OFF_FLAGS, 32'h0, "aux timer running");
		i_aux_timer_zero <= 1'b1;
		cyc(2);
		rd_chk(OFF_FLAGS, 32'h2000, "aux timer elapsed");
		i_aux_trigger <= 1'b0;
		cyc(2);
		rd_chk(OFF_FLAGS, 32'h0, "aux trigger dropped");
		i_aux_timer_zero <= 1'b0;
		wr(OFF_IRQ_STATUS, 32'hFFFF);
	endtask

	task automatic t_scan();
		wr(OFF_CONTROL, 32'h3);
		scan(16'h0005);
		rd_chk(OFF_FLAGS, 32'h8000, "overrun with zero target");
		do_init();
		wr(OFF_SCAN_TARGET, 32'h000A);
		scan(16'h000A);
		rd_chk(OFF_FLAGS, 32'h0, "scan equal to target");
		scan(16'h000B);
		rd_chk(OFF_FLAGS, 32'h8000, "scan above target");
		do_init();
		wr(OFF_CONTROL, 32'h2);
		scan(16'h0032);
		rd_chk(OFF_FLAGS, 32'h0, "no constant scan");
		rd_chk(OFF_SCAN_TARGET, 32'h000A, "scan target kept");
		wr(OFF_SCAN_TARGET, 32'h0);
	endtask

	// Event captured while masked, then unmasked, then cleared by writing one.
	task automatic t_irq();
		i_tool_port_fault <= 1'b1;
		cyc(3);
		rd_chk(OFF_IRQ_STATUS, 32'h4000, "tool port event");
		chk({31'h0, o_irq}, 32'h0, "irq while masked");
		wr(OFF_IRQ_MASK, 32'h4000);
		rd_chk(OFF_IRQ_MASK, 32'h4000, "mask readback");
		chk({31'h0, o_irq}, 32'h1, "irq unmasked");
		wr(OFF_IRQ_STATUS, 32'h4000);
		cyc(1);
		chk({31'h0, o_irq}, 32'h0, "irq after clear");
		rd_chk(OFF_IRQ_STATUS, 32'h0, "status after clear");
		i_tool_port_fault <= 1'b0;
		wr(OFF_IRQ_MASK, 32'h0);
	endtask

	// ==========================================================
	// Main sequence.
	initial begin
		{i_clock, i_read, i_write, i_init, i_self_test_fault, i_cassette_io_fault, i_cassette_fault} = 7'h0;
		{i_io_verify_fault, i_battery_fault_pin, i_op_error, i_arith_valid, i_arith_carry} = 5'h0;
		{i_arith_zero, i_shift_valid, i_shift_carry, i_cmp_valid, i_cmp_gt, i_cmp_eq, i_cmp_lt} = 7'h0;
		{i_aux_timer_zero, i_aux_trigger, i_tool_port_fault, i_scan_end} = 4'h0;
		i_rstn = 1'b0;
		i_address = 8'h00;
		i_writedata = 32'h0;
		i_byteenable = 4'hF;
		i_self_test_code = 16'h0000;
		i_op_error_addr = 16'h0000;
		i_scan_time = 16'h0000;
		fail_count = 0;
		checks_done = 0;
		cyc(5);
		i_rstn <= 1'b1;
		cyc(3);
		t_reset();
		t_readonly();
		t_self_test();
		t_levels();
		t_battery();
		t_power_off();
		t_op_error();
		t_arith();
		t_compare();
		t_aux();
		t_scan();
		t_irq();
		end_of_test();
	end

endmodule
